/* File: rtl/ppr_fabric.sv */
// peripheral pin remap fabric with wishbone register slave
`include "ppr_map.svh"

module ppr_fabric (
   input wire logic clk_i, // system clock, 100 MHz
   input wire logic rst_i, // synchronous reset, active high
   input wire logic wb_cyc_i, // bus cycle
   input wire logic wb_stb_i, // bus strobe
   input wire logic wb_we_i, // write enable
   input wire logic [11:0] wb_adr_i, // byte address
   input wire logic [3:0] wb_sel_i, // byte lanes
   input wire logic [31:0] wb_dat_i, // write data
   output logic [31:0] wb_dat_o, // read data
   output logic wb_ack_o, // acknowledge
   input wire logic [2:0] cmp_out_i, // comparator 1..3 outputs
   input wire logic [1:0] trig_out_i, // trigger outputs 26, 27
   input wire logic [2:0] pwm_event_i, // pwm events C, D, E
   input wire logic [`PPR_N_PER_OUT-1:0] per_out_i, // peripheral outputs
   output logic [`PPR_N_IN_SEL-1:0] per_in_o, // peripheral inputs
   input wire logic [`PPR_N_PHYS-1:0] pin_in_i, // pad input levels
   input wire logic [`PPR_N_PHYS-1:0] pin_analog_i, // analog select
   input wire logic [`PPR_N_PHYS-1:0] port_out_i, // port latch value
   input wire logic [`PPR_N_PHYS-1:0] port_oe_i, // port drive enable
   output logic [`PPR_N_PHYS-1:0] pin_out_o, // pad output value
   output logic [`PPR_N_PHYS-1:0] pin_oe_o, // pad output enable
   output logic map_lock_o // mapping lock state
);

   ppr_pkg::ppr_state_s q;
   ppr_pkg::ppr_state_s d;

   logic [255:0] src; // input source vector by selector code
   logic [`PPR_N_PHYS-1:0] pin_dig; // digital view of pads
   logic [`PPR_N_PER_OUT-1:0] per_out_eff; // code 0 forced low
   logic [`PPR_N_REMAP-1:0] remap_val; // selected peripheral output
   logic [`PPR_N_REMAP-1:0] remap_on; // a peripheral owns the pin
   logic [`PPR_N_IN_SEL-1:0] sel_val; // muxed peripheral inputs
   logic [`PPR_N_PHYS-1:0] drv_out; // next pad value
   logic [`PPR_N_PHYS-1:0] drv_oe; // next pad enable
   logic [31:0] rd_word; // read mux result
   logic bus_req; // request present
   logic bus_wr; // write takes effect this edge

   // analog pins give no digital input to the fabric
   assign pin_dig = q.sync2 & ~pin_analog_i;
   assign per_out_eff = {per_out_i[`PPR_N_PER_OUT-1:1], 1'b0};

   // source vector: unlisted codes stay low
   always_comb begin
      src = '0;
      src[`PPR_SRC_GND] = 1'b0;
      src[`PPR_SRC_CMP1 +: 3] = cmp_out_i;
      src[`PPR_SRC_TRIG26] = trig_out_i[0];
      src[`PPR_SRC_TRIG27] = trig_out_i[1];
      src[`PPR_SRC_EVT_C +: 3] = pwm_event_i;
      src[`PPR_SRC_PORTB0 +: `PPR_N_PORTB] =
         pin_dig[0 +: `PPR_N_PORTB];
      src[`PPR_SRC_PORTC0 +: `PPR_N_PORTC] =
         pin_dig[`PPR_PHYS_PORTC0 +: `PPR_N_PORTC];
      src[`PPR_SRC_PORTD1] = pin_dig[`PPR_PHYS_PORTD];
      src[`PPR_SRC_PORTD8] = pin_dig[`PPR_PHYS_PORTD + 1];
      src[`PPR_SRC_PORTD10] = pin_dig[`PPR_PHYS_PORTD + 2];
      src[`PPR_SRC_PORTD13] = pin_dig[`PPR_PHYS_PORTD + 3];
      // virtual pins carry whatever output mapping drives onto them
      src[`PPR_SRC_VPIN0 +: `PPR_N_VPIN] =
         remap_val[`PPR_N_PHYS +: `PPR_N_VPIN];
   end

   // per peripheral input: the selector indexes the source vector
   genvar gi;
   generate
      for (gi = 0; gi < `PPR_N_IN_SEL; gi++) begin : g_in
         assign sel_val[gi] = src[q.in_sel[gi]];
      end
   endgenerate

   // per remappable pin: the field picks a peripheral output
   genvar go;
   generate
      for (go = 0; go < `PPR_N_REMAP; go++) begin : g_out
         assign remap_val[go] = per_out_eff[q.out_sel[go]];
         assign remap_on[go] = |q.out_sel[go];
      end
   endgenerate

   // pad priority: analog first, then remap, then the port itself
   genvar gp;
   generate
      for (gp = 0; gp < `PPR_N_PHYS; gp++) begin : g_pad
         assign drv_out[gp] = pin_analog_i[gp] ? 1'b0 :
            remap_on[gp] ? remap_val[gp] : port_out_i[gp];
         assign drv_oe[gp] = pin_analog_i[gp] ? 1'b0 :
            remap_on[gp] ? 1'b1 : port_oe_i[gp];
      end
   endgenerate

   assign bus_req = wb_cyc_i & wb_stb_i;
   // writes land on the edge where the master sees ack
   assign bus_wr = bus_req & wb_we_i & q.ack;

   // register read mux; unmapped and key addresses read zero
   always_comb begin
      rd_word = 32'h0000_0000;
      if (wb_adr_i == `PPR_OFS_CTRL) begin
         rd_word[`PPR_LOCK_BIT] = q.lock;
         rd_word[`PPR_KEY_STATE_LSB +: 2] = q.key;
      end
      for (int i = 0; i < `PPR_N_IN_REG; i++) begin
         if (wb_adr_i == 12'(`PPR_OFS_IN_BASE + 4 * i)) begin
            rd_word[`PPR_SEL_LO_LSB +: 8] = q.in_sel[2 * i];
            rd_word[`PPR_SEL_HI_LSB +: 8] = q.in_sel[2 * i + 1];
         end
      end
      for (int i = 0; i < `PPR_N_OUT_REG; i++) begin
         if (wb_adr_i == 12'(`PPR_OFS_OUT_BASE + 4 * i)) begin
            rd_word[`PPR_SEL_LO_LSB +: `PPR_OUT_W] = q.out_sel[2 * i];
            rd_word[`PPR_SEL_HI_LSB +: `PPR_OUT_W] = q.out_sel[2 * i + 1];
         end
      end
   end

   // next state: synchronisers, bus slave, key tracker, mapping writes
   always_comb begin
      d = q;
      d.sync1 = pin_in_i;
      d.sync2 = q.sync1;
      d.per_in = sel_val;
      d.pin_out = drv_out;
      d.pin_oe = drv_oe;
      d.ack = bus_req & ~q.ack;
      if (bus_req & ~q.ack) begin
         d.rdata = rd_word;
      end
      if (bus_wr) begin
         // any write other than the expected key drops the sequence
         d.key = ppr_pkg::KEY_IDLE;
         if (wb_adr_i == `PPR_OFS_KEY && wb_sel_i[0]) begin
            if (wb_dat_i[7:0] == `PPR_KEY_FIRST) begin
               d.key = ppr_pkg::KEY_GOT_FIRST;
            end else if (q.key == ppr_pkg::KEY_GOT_FIRST &&
                         wb_dat_i[7:0] == `PPR_KEY_SECOND) begin
               d.key = ppr_pkg::KEY_ARMED;
            end
         end
         // lock moves only on the single write after the keys
         if (wb_adr_i == `PPR_OFS_CTRL && wb_sel_i[1] &&
             q.key == ppr_pkg::KEY_ARMED) begin
            d.lock = wb_dat_i[`PPR_LOCK_BIT];
         end
         // mapping writes ack either way but change nothing when locked
         if (!q.lock) begin
            for (int i = 0; i < `PPR_N_IN_REG; i++) begin
               if (wb_adr_i == 12'(`PPR_OFS_IN_BASE + 4 * i)) begin
                  if (wb_sel_i[0]) begin
                     d.in_sel[2 * i] =
                        wb_dat_i[`PPR_SEL_LO_LSB +: 8];
                  end
                  if (wb_sel_i[1]) begin
                     d.in_sel[2 * i + 1] =
                        wb_dat_i[`PPR_SEL_HI_LSB +: 8];
                  end
               end
            end
            for (int i = 0; i < `PPR_N_OUT_REG; i++) begin
               if (wb_adr_i == 12'(`PPR_OFS_OUT_BASE + 4 * i)) begin
                  if (wb_sel_i[0]) begin
                     d.out_sel[2 * i] =
                        wb_dat_i[`PPR_SEL_LO_LSB +: `PPR_OUT_W];
                  end
                  if (wb_sel_i[1]) begin
                     d.out_sel[2 * i + 1] =
                        wb_dat_i[`PPR_SEL_HI_LSB +: `PPR_OUT_W];
                  end
               end
            end
         end
      end
   end

   // state register; selectors reset to ground, outputs to none
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
         q.lock <= `PPR_LOCK_RST;
         q.key <= ppr_pkg::KEY_IDLE;
         q.in_sel <= {`PPR_N_IN_SEL{`PPR_SEL_RST}};
         q.out_sel <= {`PPR_N_REMAP{`PPR_OUT_RST}};
      end else begin
         q <= d;
      end
   end

   // outputs straight from the state register
   assign wb_dat_o = q.rdata;
   assign wb_ack_o = q.ack;
   assign per_in_o = q.per_in;
   assign pin_out_o = q.pin_out;
   assign pin_oe_o = q.pin_oe;
   assign map_lock_o = q.lock;

endmodule : ppr_fabric

/* File: rtl/ppr_map.svh */
// register offsets, field positions, reset values and codes of the remap fabric
`ifndef PPR_MAP_SVH
`define PPR_MAP_SVH

// sizes of the fabric
`define PPR_N_IN_REG 8
`define PPR_N_IN_SEL 16
`define PPR_N_OUT_REG 20
`define PPR_N_REMAP 40
`define PPR_N_PHYS 34
`define PPR_N_VPIN 6
`define PPR_N_PER_OUT 64

// byte offsets on the register bus
`define PPR_OFS_CTRL 12'h000
`define PPR_OFS_KEY 12'h004
`define PPR_OFS_IN_BASE 12'h100
`define PPR_OFS_OUT_BASE 12'h200

// field positions
`define PPR_LOCK_BIT 11
`define PPR_KEY_STATE_LSB 0
`define PPR_SEL_LO_LSB 0
`define PPR_SEL_HI_LSB 8
`define PPR_OUT_W 6

// reset values
`define PPR_LOCK_RST 1'b0
`define PPR_SEL_RST 8'h00
`define PPR_OUT_RST 6'h00

// unlock key values
`define PPR_KEY_FIRST 8'h55
`define PPR_KEY_SECOND 8'hAA

// input selector source codes
`define PPR_SRC_GND 0
`define PPR_SRC_CMP1 1
`define PPR_SRC_TRIG26 6
`define PPR_SRC_TRIG27 7
`define PPR_SRC_EVT_C 11
`define PPR_SRC_PORTB0 32
`define PPR_SRC_PORTC0 48
`define PPR_SRC_PORTD1 65
`define PPR_SRC_PORTD8 72
`define PPR_SRC_PORTD10 74
`define PPR_SRC_PORTD13 77
`define PPR_SRC_VPIN0 176

// physical pin index ranges
`define PPR_N_PORTB 16
`define PPR_N_PORTC 14
`define PPR_PHYS_PORTC0 16
`define PPR_PHYS_PORTD 30

`endif

/* File: rtl/ppr_pkg.sv */
// types shared by the remap fabric
package ppr_pkg;
`include "ppr_map.svh"

   // unlock key tracker
   typedef enum logic [1:0] {
      KEY_IDLE = 2'b00,
      KEY_GOT_FIRST = 2'b01,
      KEY_ARMED = 2'b10
   } ppr_key_e;

   // whole state of the fabric
   typedef struct packed {
      logic lock;
      ppr_key_e key;
      logic ack;
      logic [31:0] rdata;
      logic [`PPR_N_IN_SEL-1:0][7:0] in_sel;
      logic [`PPR_N_REMAP-1:0][`PPR_OUT_W-1:0] out_sel;
      logic [`PPR_N_PHYS-1:0] sync1;
      logic [`PPR_N_PHYS-1:0] sync2;
      logic [`PPR_N_IN_SEL-1:0] per_in;
      logic [`PPR_N_PHYS-1:0] pin_out;
      logic [`PPR_N_PHYS-1:0] pin_oe;
   } ppr_state_s;

endpackage : ppr_pkg

/* File: sim/ppr_fabric_asserts.sv */
// checker of bus, lock and pad rules of the remap fabric
`include "ppr_map.svh"
module ppr_fabric_asserts (
   input wire logic clk_i, // clock
   input wire logic rst_i, // reset
   input wire logic wb_cyc_i, // cycle
   input wire logic wb_stb_i, // strobe
   input wire logic wb_we_i, // write
   input wire logic [11:0] wb_adr_i, // address
   input wire logic [31:0] wb_dat_o, // read data
   input wire logic wb_ack_o, // acknowledge
   input wire logic [`PPR_N_IN_SEL-1:0] per_in_o, // peripheral inputs
   input wire logic [`PPR_N_PHYS-1:0] pin_analog_i, // analog
   input wire logic [`PPR_N_PHYS-1:0] pin_out_o, // pad value
   input wire logic [`PPR_N_PHYS-1:0] pin_oe_o, // pad enable
   input wire logic map_lock_o // lock
);
   logic ctrl_wr;
   default clocking dc @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   // a control write landing at this edge
   assign ctrl_wr = wb_ack_o && wb_we_i && wb_adr_i == `PPR_OFS_CTRL;
   // a control read being answered
   sequence ctrl_rd_s;
      wb_ack_o && !wb_we_i && wb_adr_i == `PPR_OFS_CTRL;
   endsequence
   req_ack_a: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not acknowledged");
   ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   rst_state_a: assert property (
      $fell(rst_i) |-> !map_lock_o && per_in_o == '0)
      else $error("state after reset wrong");
   lock_src_a: assert property (
      $changed(map_lock_o) |-> $past(ctrl_wr))
      else $error("lock changed without control write");
   lock_keep_a: assert property (
      !wb_ack_o |=> $stable(map_lock_o))
      else $error("lock moved with no access");
   lock_read_a: assert property (
      ctrl_rd_s |-> wb_dat_o[`PPR_LOCK_BIT] == map_lock_o)
      else $error("lock bit reads wrong");
   analog_oe_a: assert property (
      1'b1 |=> (pin_oe_o & $past(pin_analog_i)) == '0)
      else $error("analog pad driven");
   analog_out_a: assert property (
      1'b1 |=> (pin_out_o & $past(pin_analog_i)) == '0)
      else $error("analog pad shows a value");
endmodule : ppr_fabric_asserts

bind ppr_fabric ppr_fabric_asserts chk_u (.clk_i, .rst_i, .wb_cyc_i,
   .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .per_in_o,
   .pin_analog_i, .pin_out_o, .pin_oe_o, .map_lock_o);

/* File: sim/ppr_partner.sv */
// far side model: peripheral sources and pad levels around the fabric
module ppr_partner (
   input wire logic inv_i, // flip every source level
   output logic [2:0] cmp_o, // comparators 1..3
   output logic [1:0] trig_o, // trigger outputs 26, 27
   output logic [2:0] pwm_o, // pwm events C, D, E
   output logic [63:0] per_o, // peripheral outputs
   output logic [33:0] pad_o, // pad levels
   output logic [33:0] ana_o, // analog select
   output logic [33:0] lat_o, // port latch
   output logic [33:0] drv_o // port drive enable
);
   timeunit 1ns;
   timeprecision 1ns;
   // alternating levels so a neighbouring source never matches
   assign cmp_o = 3'h5 ^ {3{inv_i}};
   assign trig_o = 2'h1 ^ {2{inv_i}};
   assign pwm_o = 3'h5 ^ {3{inv_i}};
   assign per_o = 64'hAAAAAAAAAAAAAAAA ^ {64{inv_i}};
   assign pad_o = 34'h155555555 ^ {34{inv_i}};
   assign lat_o = ~pad_o;
   assign drv_o = 34'h3FFFFFFFF;
   // pad 1 turns analog while flipped
   assign ana_o = {32'h0, inv_i, 1'b0};
endmodule : ppr_partner

/* File: sim/test_peripheral_pin_remap.sv */
// self-checking bench for the remap fabric
`include "ppr_map.svh"
module test_peripheral_pin_remap;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [11:0] wb_adr_i = 12'h000;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o, rd;
   logic wb_ack_o, map_lock_o, inv = 1'b0;
   logic [2:0] cmp_out_i, pwm_event_i;
   logic [1:0] trig_out_i;
   logic [63:0] per_out_i;
   logic [15:0] per_in_o;
   logic [33:0] pin_in_i, pin_analog_i, port_out_i, port_oe_i;
   logic [33:0] pin_out_o, pin_oe_o;
   int err_total = 0;
   int checked = 0;
   // selector codes under test and their expected levels
   logic [7:0] cd [25] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h06,
      8'h07, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h20, 8'h21, 8'h2F, 8'h30,
      8'h3D, 8'h3E, 8'h41, 8'h48, 8'h4A, 8'h4D, 8'h4E, 8'hB0, 8'hB5, 8'hFF};
   logic [24:0] e0 = 25'h04A4AAA; // level with sources unflipped
   logic [24:0] fl = 25'h0DEEBEE; // entries that follow the flip

   always #5 clk_i = ~clk_i;

   ppr_partner far_u (.inv_i(inv), .cmp_o(cmp_out_i), .trig_o(trig_out_i),
      .pwm_o(pwm_event_i), .per_o(per_out_i), .pad_o(pin_in_i),
      .ana_o(pin_analog_i), .lat_o(port_out_i), .drv_o(port_oe_i));
   ppr_fabric dut_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i(wb_cyc_i),
      .wb_we_i, .wb_adr_i, .wb_sel_i(4'h3), .wb_dat_i, .wb_dat_o,
      .wb_ack_o, .cmp_out_i, .trig_out_i, .pwm_event_i, .per_out_i,
      .per_in_o, .pin_in_i, .pin_analog_i, .port_out_i, .port_oe_i,
      .pin_out_o, .pin_oe_o, .map_lock_o);

   // compare and count
   task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
      checked++;
      if (s !== x) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, x, s);
      end
   endtask : chk

   // one classic cycle, held until ack is sampled
   task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      rd = wb_dat_o;
      chk("ack", wb_ack_o, 1'b1);
      wb_cyc_i <= 1'b0;
   endtask : bus

   // key pair then one control write
   task relock(input logic [31:0] v);
      bus(1'b1, `PPR_OFS_KEY, 32'h55);
      bus(1'b1, `PPR_OFS_KEY, 32'hAA);
      bus(1'b1, `PPR_OFS_CTRL, v);
      @(posedge clk_i);
      chk("lock", map_lock_o, v[11]);
   endtask : relock

   task complete_run;
      $display("checked %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : complete_run

   // main sequence
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk("lock_rst", map_lock_o, 1'b0);
      chk("in_rst", per_in_o, 16'h0);
      bus(1'b0, 12'h200, 32'h0);
      chk("out_rst", rd, 32'h0);
      chk("pad_rst", pin_out_o[0], 1'b0);
      bus(1'b1, 12'h200, 32'h5);
      bus(1'b1, 12'h244, 32'h5);
      bus(1'b1, 12'h24C, 32'h400);
      for (int v = 0; v < 2; v++) begin
         inv <= v[0];
         for (int i = 0; i < 25; i++) begin
            bus(1'b1, 12'h100, {16'h0, cd[(i + 1) % 25], cd[i]});
            repeat (5) @(posedge clk_i);
            chk("sel_lo", per_in_o[0], e0[i] ^ (fl[i] & v[0]));
            chk("sel_hi", per_in_o[1],
               e0[(i + 1) % 25] ^ (fl[(i + 1) % 25] & v[0]));
         end
         chk("pad_map", pin_out_o[0], !v[0]);
         chk("pad_oe", pin_oe_o[1], !v[0]);
         chk("in_rest", per_in_o[15:2], 14'h0);
      end
      relock(32'h800);
      bus(1'b1, 12'h100, 32'h2120);
      bus(1'b0, 12'h100, 32'h0);
      chk("locked", rd, 32'h00FF);
      bus(1'b1, `PPR_OFS_KEY, 32'h55);
      bus(1'b1, 12'h104, 32'h0);
      bus(1'b1, `PPR_OFS_KEY, 32'hAA);
      bus(1'b1, `PPR_OFS_CTRL, 32'h0);
      bus(1'b0, `PPR_OFS_CTRL, 32'h0);
      chk("broken_key", rd[11], 1'b1);
      relock(32'h0);
      bus(1'b1, 12'h100, 32'h2120);
      bus(1'b0, 12'h100, 32'h0);
      chk("unlocked", rd, 32'h2120);
      bus(1'b1, 12'h0FC, 32'hFFFF);
      bus(1'b0, 12'h0FC, 32'h0);
      chk("unmapped", rd, 32'h0);
      complete_run();
   end

   // watchdog against a hung handshake
   initial begin
      #100000;
      err_total++;
      complete_run();
   end
endmodule : test_peripheral_pin_remap
